// >>> hdl/fkd_params.svh
// Offsets, field positions, reset values and counts of the flash key block
`ifndef FKD_PARAMS_SVH
`define FKD_PARAMS_SVH

// Register byte offsets on APB (paddr[11:0])
`define FKD_KEY_OFS 12'h000
`define FKD_DEST_OFS 12'h004
`define FKD_CTRL_OFS 12'h008
`define FKD_STAT_OFS 12'h00c

// Key codes and reset value
`define FKD_KEY_DL 8'ha5
`define FKD_KEY_PE 8'h5a
`define FKD_RST_BYTE 8'h00

// Field positions
`define FKD_ERR_BIT 7
`define FKD_REQ_BIT 0

// Destination selector range and RAM placement
`define FKD_SEL_MIN 7'h02
`define FKD_SEL_MAX 7'h04
`define FKD_RAM_BASE0 32'hffff9000
`define FKD_BLOCK_BYTES 32'h00000800

// Routine length in 32-bit words
`define FKD_DL_WORDS 5'h10

`endif

// >>> hdl/fkd_pkg.sv
// Types and shared decode functions of the flash key block
package fkd_pkg;

  // One RAM write beat
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
  } fkd_ram_wr_t;

  // Download engine states
  typedef enum logic [1:0] {
    FKD_IDLE = 2'b00,
    FKD_COPY = 2'b01,
    FKD_DRAIN = 2'b10,
    FKD_ABORT = 2'b11
  } fkd_dl_state_t;

  // Selector lies in the permitted window
  function automatic logic selOk(input logic [6:0] sel);
    selOk = (sel >= 7'h02) && (sel <= 7'h04);
  endfunction

  // RAM start address for a selector, 2 kbyte steps
  function automatic logic [31:0] destBase(input logic [6:0] sel);
    destBase = 32'hffff9000 + {14'h0000, sel, 11'h000};
  endfunction

endpackage

// >>> hdl/fkd_download_engine.sv
// Copies the stored routine into on-chip RAM at the selected start address
`timescale 1ns/1ns
`include "fkd_params.svh"

module fkd_download_engine (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control from the register block
  input wire logic start,
  input wire logic [6:0] destSel,
  output logic busy_q,
  output logic done_q,
  output logic addrErr_q,
  // Routine store, synchronous read
  output logic [3:0] romAddr_q,
  input wire logic [31:0] romData,
  // RAM write port
  output fkd_pkg::fkd_ram_wr_t ramWr_q
);

  fkd_pkg::fkd_dl_state_t stateQ; // Sequencer state
  logic [4:0] cntQ;               // Next word to fetch
  logic pendQ; // Address presented to the store
  logic [3:0] pendIdxQ; // Index of that address
  logic pend2Q; // Store answer stands on romData
  logic [3:0] pend2IdxQ; // Index of that answer
  logic [31:0] baseQ;             // Start address latched at start

  //////////////////////////////////////////////////////////////////////////
  // Sequencer: check selector, then fetch every word once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= fkd_pkg::FKD_IDLE;
      cntQ <= 5'h00;
      baseQ <= 32'h00000000;
      romAddr_q <= 4'h0;
      pendQ <= 1'b0;
      pendIdxQ <= 4'h0;
    end else begin
      pendQ <= 1'b0;
      case (stateQ)
        fkd_pkg::FKD_IDLE: begin
          if (start) begin
            // Bad selector never touches RAM
            if (fkd_pkg::selOk(destSel)) begin
              stateQ <= fkd_pkg::FKD_COPY;
              baseQ <= fkd_pkg::destBase(destSel);
              cntQ <= 5'h00;
            end else begin
              stateQ <= fkd_pkg::FKD_ABORT;
            end
          end
        end
        fkd_pkg::FKD_COPY: begin
          romAddr_q <= cntQ[3:0];
          pendQ <= 1'b1;
          pendIdxQ <= cntQ[3:0];
          cntQ <= cntQ + 5'h01;
          if (cntQ == `FKD_DL_WORDS - 5'h01) begin
            stateQ <= fkd_pkg::FKD_DRAIN;
          end
        end
        // Last word is fetched while leaving, written two cycles later
        fkd_pkg::FKD_DRAIN: stateQ <= fkd_pkg::FKD_IDLE;
        fkd_pkg::FKD_ABORT: stateQ <= fkd_pkg::FKD_IDLE;
        default: stateQ <= fkd_pkg::FKD_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Second stage: the store answers one cycle after its address, so
  // word and index only meet here; one stage less would shift the data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend2Q <= 1'b0;
      pend2IdxQ <= 4'h0;
    end else begin
      pend2Q <= pendQ;
      pend2IdxQ <= pendIdxQ;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // RAM write beat, taken while the stored word stands on romData
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ramWr_q <= '0;
    end else begin
      ramWr_q.we <= pend2Q;
      ramWr_q.addr <= baseQ + {26'h0000000, pend2IdxQ, 2'b00};
      ramWr_q.data <= romData;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status flags toward the register block
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      addrErr_q <= 1'b0;
    end else begin
      // Busy until the last beat has left the pipeline
      busy_q <= (stateQ != fkd_pkg::FKD_IDLE) || pendQ || pend2Q;
      // Done with the last beat, so the request never clears early
      done_q <= (stateQ == fkd_pkg::FKD_ABORT) || (pend2Q && pend2IdxQ == 4'hf);
      addrErr_q <= (stateQ == fkd_pkg::FKD_ABORT);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // First word lands at the selected base
  first_word_a: assert property (
    start && fkd_pkg::selOk(destSel) |-> ##4 ramWr_q.we &&
      ramWr_q.addr == fkd_pkg::destBase($past(destSel, 4)))
    else $error("first RAM word not at selected base");
  // Every write stays inside the three 2 kbyte windows
  ram_window_a: assert property (
    ramWr_q.we |-> ramWr_q.addr >= 32'hffffa000 && ramWr_q.addr < 32'hffffb800)
    else $error("RAM write outside download window");
  // Bad selector: abort flag two cycles on, no write in that cycle
  bad_sel_a: assert property (
    start && !fkd_pkg::selOk(destSel) && stateQ == fkd_pkg::FKD_IDLE
      |-> ##2 addrErr_q && done_q && !ramWr_q.we)
    else $error("bad selector not aborted");

endmodule

// >>> hdl/fkd_top.sv
// APB-reachable flash key and download-destination control block
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "fkd_params.svh"

// Function
// - 8-bit key register, clears to zero
// - Request bit settable only with download key
// - Other key values ignore request writes
// - Program/erase allowed only with program key
// - Other keys block program and erase
// - Destination register: error bit, 7-bit selector
// - Destination register picks RAM start address
// - Selectors 2..4 map 2-kbyte RAM windows
// - Bad selector sets error, aborts download
// - Request bit clears itself when download ends
module fkd_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Program/erase requests from the running routine
  input wire logic opReq,
  output logic progEraseEn_q,
  output logic flashOpGo_q,
  output logic flashOpBlocked_q,
  // Routine store and RAM write port
  output logic [3:0] romAddr_q,
  input wire logic [31:0] romData,
  output fkd_pkg::fkd_ram_wr_t ramWr_q,
  output logic dlBusy_q
);

  logic [7:0] keyQ;      // Unlock key
  logic destErrQ;        // Address error flag
  logic [6:0] destSelQ;  // Destination selector
  logic reqQ;            // Download request bit
  logic startQ;          // One-cycle start to engine
  logic engBusy;         // Engine copying
  logic engDone;         // Engine finished or aborted
  logic engErr;          // Engine rejected selector
  logic apbWr;           // Write completes this edge
  logic apbAccess;       // First access cycle, answer being formed
  logic dlKeyOk;         // Key holds download value
  logic peKeyOk;         // Key holds program/erase value
  logic reqAttempt;      // Software writes one to request bit
  logic [31:0] rdMux;    // Read data for current address
  logic mapped;          // Address hits a register

  assign dlKeyOk = (keyQ == `FKD_KEY_DL);
  assign peKeyOk = (keyQ == `FKD_KEY_PE);

  //////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait cycle so read data leaves a flop
  assign apbAccess = psel && penable && !pready_q;
  assign apbWr = psel && penable && pready_q && pwrite && mapped;
  assign reqAttempt = apbWr && (paddr == `FKD_CTRL_OFS) && pwdata[`FKD_REQ_BIT];

  // Address decode, aligned words only
  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h00000000;
    case (paddr)
      `FKD_KEY_OFS: rdMux = {24'h000000, keyQ};
      `FKD_DEST_OFS: rdMux = {24'h000000, destErrQ, destSelQ};
      `FKD_CTRL_OFS: rdMux = {31'h00000000, reqQ};
      `FKD_STAT_OFS: rdMux = {28'h0000000, destErrQ, peKeyOk, dlKeyOk, engBusy};
      default: mapped = 1'b0;
    endcase
  end

  // Ready, error and read data flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (apbAccess) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      // Writes and unmapped reads return zero
      prdata_q <= pwrite ? 32'h00000000 : rdMux;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Key register, plain read/write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      keyQ <= `FKD_RST_BYTE;
    end else if (apbWr && paddr == `FKD_KEY_OFS) begin
      keyQ <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Destination selector; engine latches it at start, so late writes
  // during a copy do not move a download already running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      destSelQ <= 7'h00;
    end else if (apbWr && paddr == `FKD_DEST_OFS) begin
      destSelQ <= pwdata[6:0];
    end
  end

  // Error flag: hardware set beats a software write in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      destErrQ <= 1'b0;
    end else if (engErr) begin
      destErrQ <= 1'b1;
    end else if (apbWr && paddr == `FKD_DEST_OFS) begin
      destErrQ <= pwdata[`FKD_ERR_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request bit: set only under download key, cleared by the engine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reqQ <= 1'b0;
      startQ <= 1'b0;
    end else begin
      startQ <= 1'b0;
      if (engDone) begin
        reqQ <= 1'b0;
      end else if (reqAttempt && dlKeyOk && !reqQ && !engBusy) begin
        reqQ <= 1'b1;
        startQ <= 1'b1;
      end
      // Any other key leaves the bit and engine untouched
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Program/erase gate; the routine itself cannot bypass the key check
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      progEraseEn_q <= 1'b0;
      flashOpGo_q <= 1'b0;
      flashOpBlocked_q <= 1'b0;
    end else begin
      progEraseEn_q <= peKeyOk;
      flashOpGo_q <= opReq && peKeyOk;
      flashOpBlocked_q <= opReq && !peKeyOk;
    end
  end

  // Busy seen by the system: from request until engine is idle again
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dlBusy_q <= 1'b0;
    end else begin
      dlBusy_q <= reqQ || engBusy;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Copy engine
  fkd_download_engine engine (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(startQ),
    .destSel(destSelQ),
    .busy_q(engBusy),
    .done_q(engDone),
    .addrErr_q(engErr),
    .romAddr_q(romAddr_q),
    .romData(romData),
    .ramWr_q(ramWr_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int DlSpan = 24; // Request to clear, with margin

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Key write shows on next edge
  key_write_a: assert property (
    apbWr && paddr == `FKD_KEY_OFS |=> keyQ == $past(pwdata[7:0]))
    else $error("key write not stored");
  // Request bit only rises under download key
  req_key_a: assert property (
    $rose(reqQ) |-> $past(keyQ) == `FKD_KEY_DL && $past(reqAttempt))
    else $error("request set without download key");
  // Wrong key: bit stays low and no start
  req_block_a: assert property (
    reqAttempt && !dlKeyOk && !reqQ |=> !reqQ && !startQ ##1 !engBusy)
    else $error("request accepted under wrong key");
  // Operation passes only with program key
  op_go_a: assert property (
    flashOpGo_q |-> $past(opReq) && $past(keyQ) == `FKD_KEY_PE)
    else $error("flash op passed without key");
  // Any other key blocks the operation
  op_block_a: assert property (
    opReq && !peKeyOk |=> !flashOpGo_q && flashOpBlocked_q)
    else $error("flash op not blocked");
  // Destination write stores selector and flag
  dest_write_a: assert property (
    apbWr && paddr == `FKD_DEST_OFS && !engErr |=>
      {destErrQ, destSelQ} == $past(pwdata[7:0]))
    else $error("destination write not stored");
  // Engine error sets flag even against a clearing write
  err_sticky_a: assert property (
    engErr |=> destErrQ)
    else $error("address error flag not set");
  // Start reaches the engine within a bounded span and clears the bit
  req_clear_a: assert property (
    $rose(reqQ) |-> ##[3:DlSpan] !reqQ)
    else $error("request bit not cleared");
  // Read answer lands one cycle into access
  apb_ready_a: assert property (
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("APB ready timing wrong");

  //////////////////////////////////////////////////////////////////////////
  // Bus answer checks
  // Error answer only for places outside the map
  unmapped_err_a: assert property (
    apbAccess |=> pslverr_q == !$past(mapped))
    else $error("APB error answer wrong");
  // Between answers the bus outputs rest at zero
  apb_idle_a: assert property (
    !pready_q |-> prdata_q == 32'h00000000 && !pslverr_q)
    else $error("APB outputs not idle");
  // Key read returns the stored byte, upper bits zero
  key_read_a: assert property (
    apbAccess && !pwrite && paddr == `FKD_KEY_OFS |=>
      prdata_q == {24'h000000, $past(keyQ)})
    else $error("key read wrong");
  // Destination read shows flag above selector
  dest_read_a: assert property (
    apbAccess && !pwrite && paddr == `FKD_DEST_OFS |=>
      prdata_q == {24'h000000, $past(destErrQ), $past(destSelQ)})
    else $error("destination read wrong");
  // Control read shows the request bit alone
  ctrl_read_a: assert property (
    apbAccess && !pwrite && paddr == `FKD_CTRL_OFS |=>
      prdata_q == {31'h00000000, $past(reqQ)})
    else $error("control read wrong");
  // Status word: flag, key classes, engine busy
  status_read_a: assert property (
    apbAccess && !pwrite && paddr == `FKD_STAT_OFS |=>
      prdata_q == {28'h0000000, $past(destErrQ), $past(peKeyOk),
        $past(dlKeyOk), $past(engBusy)})
    else $error("status read wrong");

  //////////////////////////////////////////////////////////////////////////
  // Register contents and key gating checks
  // Writes outside the map leave the registers alone
  unmapped_wr_a: assert property (
    psel && penable && pready_q && pwrite && !mapped |=>
      $stable(keyQ) && $stable(destSelQ))
    else $error("unmapped write changed a register");
  // Selector moves only on a destination write
  sel_hold_a: assert property (
    !(apbWr && paddr == `FKD_DEST_OFS) |=> $stable(destSelQ))
    else $error("selector changed without write");
  // Error flag falls only by a software write
  err_hold_a: assert property (
    destErrQ && !(apbWr && paddr == `FKD_DEST_OFS) |=> destErrQ)
    else $error("address error flag lost");
  // Start is a single pulse, only under the download key
  start_pulse_a: assert property (
    startQ |-> !$past(startQ) && $past(dlKeyOk) && reqQ)
    else $error("start not a single keyed pulse");
  // Wrong key never moves the engine
  no_start_a: assert property (
    reqAttempt && !dlKeyOk |=> !startQ)
    else $error("engine started under wrong key");
  // Enable follows the key with one cycle of lag
  pe_enable_a: assert property (
    progEraseEn_q == $past(peKeyOk))
    else $error("program enable does not follow key");
  // Go and blocked never answer together
  op_excl_a: assert property (
    !(flashOpGo_q && flashOpBlocked_q))
    else $error("flash op both passed and blocked");
  // System busy covers the whole pending request
  busy_span_a: assert property (
    reqQ |=> dlBusy_q)
    else $error("busy low while request pending");

  full_copy_c: cover property ($rose(reqQ) ##[1:DlSpan] engDone && !engErr);
  abort_c: cover property (engErr && destErrQ == 1'b0);
  blocked_req_c: cover property (reqAttempt && !dlKeyOk);
  op_pass_c: cover property (flashOpGo_q);
  err_clear_c: cover property (destErrQ ##1 !destErrQ);

endmodule

// >>> tb/fkd_top_tb_top.sv
// Self-checking bench of the flash key and download-destination block
`timescale 1ns/1ns

module fkd_top_tb_top;
  ////////////////////////////////////////////////////////////////////////
  // Clock, reset, APB and routine-side stimulus
  logic mclk;
  logic rst_n;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, romData, rd, wrBase;
  logic [3:0] romAddr;
  logic opReq, peEn, opGo, opBlk, dlBusy;
  fkd_pkg::fkd_ram_wr_t ramWr;
  int nFail, testsRun, wrCount, i;
  // One register access: address, direction, data in, read data and error out
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  row_t rows [12];

  fkd_top uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata),
    .pready_q(pready), .pslverr_q(pslverr), .opReq(opReq), .progEraseEn_q(peEn),
    .flashOpGo_q(opGo), .flashOpBlocked_q(opBlk), .romAddr_q(romAddr),
    .romData(romData), .ramWr_q(ramWr), .dlBusy_q(dlBusy));

  ////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("Counts: %0d compares, %0d mismatches", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Holds the request until pready is seen at an edge, as APB asks
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0000dead, 32'h00000000);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(a, 1'b1, d, rd, e);
  endtask

  // Polls the request bit until the engine lets it go
  task automatic waitReqClear();
    logic e;
    int n;
    n = 0;
    do begin
      apb(12'h008, 1'b0, 32'h0, rd, e);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    check(rd, 32'h00000000);
  endtask

  // One routine request; go or blocked shows one cycle later
  task automatic opPulse(input logic expGo);
    @(posedge mclk);
    opReq <= 1'b1;
    @(posedge mclk);
    opReq <= 1'b0;
    @(posedge mclk);
    check({opGo, opBlk}, {expGo, !expGo});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock, routine store with one-cycle read, RAM beat monitor
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Word pattern carries its index so order and pairing show up
  always @(posedge mclk) romData <= {16'hc0de, 12'h000, romAddr};

  // Each beat lands at base plus four times its index
  always @(posedge mclk) begin
    if (ramWr.we === 1'b1) begin
      check(ramWr.addr, wrBase + 32'(wrCount * 4));
      check(ramWr.data, {16'hc0de, 12'h000, 4'(wrCount)});
      wrCount++;
    end
  end

  // Watchdog well beyond the expected run
  initial begin
    #(50 * 20000);
    nFail++;
    giveVerdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic e;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; opReq = 1'b0;
    wrBase = 32'h0; nFail = 0; testsRun = 0; wrCount = 0;
    // Reset values, access kinds, unmapped place, status decode
    rows = '{'{12'h000, 0, 32'h0, 32'h00, 0}, '{12'h004, 0, 32'h0, 32'h00, 0},
      '{12'h008, 0, 32'h0, 32'h00, 0}, '{12'h000, 1, 32'h3c, 32'h00, 0},
      '{12'h000, 0, 32'h0, 32'h3c, 0}, '{12'h004, 1, 32'hff, 32'h00, 0},
      '{12'h004, 0, 32'h0, 32'hff, 0}, '{12'h010, 0, 32'h0, 32'h00, 1},
      '{12'h000, 1, 32'h123456a5, 32'h00, 0}, '{12'h000, 0, 32'h0, 32'ha5, 0},
      '{12'h00c, 0, 32'h0, 32'h0a, 0}, '{12'h010, 1, 32'h5a, 32'h00, 1}};
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i++) begin
      apb(rows[i].a, rows[i].w, rows[i].d, rd, e);
      if (!rows[i].w) check(rd, rows[i].q);
      check({31'h0, e}, {31'h0, rows[i].e});
    end
    $display("Test register table done");
    // Request refused under a wrong key
    wr(12'h004, 32'h03);
    wr(12'h000, 32'h5b);
    wr(12'h008, 32'h01);
    apb(12'h008, 1'b0, 32'h0, rd, e);
    check(rd, 32'h00000000);
    check({31'h0, dlBusy}, 32'h0);
    check(32'(wrCount), 32'h0);
    $display("Test refused request done");
    // Good download to selector 3, set up in the documented order
    wrBase = 32'hffffa800;
    wr(12'h000, 32'ha5);
    wr(12'h008, 32'h01);
    repeat (2) @(posedge mclk);
    check({31'h0, dlBusy}, 32'h1);
    waitReqClear();
    check(32'(wrCount), 32'd16);
    $display("Test download done");
    // Selectors just above and just below the window abort and flag
    wr(12'h004, 32'h05);
    wr(12'h008, 32'h01);
    waitReqClear();
    apb(12'h004, 1'b0, 32'h0, rd, e);
    check(rd, 32'h00000085);
    check(32'(wrCount), 32'd16);
    wr(12'h004, 32'h01);
    wr(12'h008, 32'h01);
    waitReqClear();
    apb(12'h004, 1'b0, 32'h0, rd, e);
    check(rd, 32'h00000081);
    $display("Test bad selector done");
    // Program/erase gate under download and program keys
    opPulse(1'b0);
    wr(12'h000, 32'h5a);
    @(posedge mclk);
    @(posedge mclk);
    check({31'h0, peEn}, 32'h1);
    opPulse(1'b1);
    wr(12'h000, 32'ha5);
    opPulse(1'b0);
    $display("Test program gate done");
    // Second reset in mid-run clears the key
    wr(12'h000, 32'h5a);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    apb(12'h000, 1'b0, 32'h0, rd, e);
    check(rd, 32'h00000000);
    apb(12'h004, 1'b0, 32'h0, rd, e);
    check(rd, 32'h00000000);
    $display("Test second reset done");
    giveVerdict();
  end
endmodule
